// ---- core/ccsc_bank.sv ----
// Configuration command/status and class/revision register bank behind APB
// Function
// - Devsel timing field reads constant 01, medium decode.
// - Data parity reported sets only when PERR was seen, the device was master and parity response on.
// - Fast back-to-back capable bit always reads one.
// - Capabilities-list bit reports whether an extended capability list exists.
// - With system-error response on, an address-phase parity error asserts the system error output.
// - With parity response off (its reset value) data parity errors are ignored; address parity errors still reach the system error output.
// - With parity response on, a detected parity error on parity_err sets host status bit 13.
// - Bus mastering is allowed only while the master enable is one; it resets to one.
// - Memory-space accesses are answered only while memory space enable is one.
// - I/O-space accesses are answered only while I/O space enable is one.
// - Base class field reads as network controller.
// - Subclass field reads as Fast Ethernet controller.
// - Low byte of the class register holds revision and step fields.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module ccsc_bank
  import ccsc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1,  // Arbitrary value
  parameter logic [3:0] STEP     = 4'h0,  // Arbitrary value
  parameter bit         HAS_CAPS = 1'b1
)
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus-side events
  input  wire logic        perr_seen,
  input  wire logic        master_active,
  input  wire logic        addr_parity_err,
  input  wire logic        parity_err,
  input  wire logic        mem_access,
  input  wire logic        io_access,
  input  wire logic        master_request,
  // Enables and indications toward the core
  output logic             mem_respond,
  output logic             io_respond,
  output logic             master_grant_ok,
  output logic             serr_assert,
  output logic             host_syserr,
  output logic             irq
);
  typedef struct packed {
    logic        syserr_response_enable;
    logic        parity_response_enable;
    logic        bus_master_enable;
    logic        memory_space_enable;
    logic        io_space_enable;
    logic        data_parity_reported;
    logic        host_syserr;
    logic        serr;
    logic [31:0] rdata;
    logic        slverr;
  } ccsc_bank_state_type;
  ccsc_bank_state_type state;
  ccsc_bank_state_type next_state;

  // Layout guard: every read view must fit one 32-bit word
  if (EV_COUNT < 1 || EV_COUNT > 32 || HOST_SYSERR_BIT > 31) begin : g_bad_layout
    $error("register layout does not fit one word");
  end

  ccsc_irq_if irq_bus ();
  logic        wr_acc;
  logic        rd_acc;
  logic        dpr_event;
  logic        serr_event;
  logic        hse_event;
  logic [31:0] cmd_word;
  logic [31:0] class_word;

  // Single-cycle access phase, answered at once
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && !penable && !pwrite;

  // Event qualifiers
  assign dpr_event  = perr_seen && master_active && state.parity_response_enable;
  assign serr_event = addr_parity_err && state.syserr_response_enable;
  assign hse_event  = parity_err && state.parity_response_enable;

  // Read views; unlisted bits stay zero
  always_comb begin
    cmd_word = '0;
    cmd_word[DEVSEL_MSB:DEVSEL_LSB] = DEVSEL_MEDIUM;
    cmd_word[DPR_BIT]        = state.data_parity_reported;
    cmd_word[FAST_B2B_BIT]   = 1'b1;
    cmd_word[CAP_LIST_BIT]   = HAS_CAPS;
    cmd_word[SYSERR_RSP_BIT] = state.syserr_response_enable;
    cmd_word[PARITY_RSP_BIT] = state.parity_response_enable;
    cmd_word[MASTER_BIT]     = state.bus_master_enable;
    cmd_word[MEM_SPACE_BIT]  = state.memory_space_enable;
    cmd_word[IO_SPACE_BIT]   = state.io_space_enable;
    class_word = '0;
    class_word[CLASS_BASE_LSB +: 8] = BASE_CLASS_NET;
    class_word[CLASS_SUB_LSB +: 8]  = SUBCLASS_FE;
    class_word[CLASS_REV_LSB +: 4]  = REVISION;
    class_word[3:0]                 = STEP;
  end

  // Register writes, read capture and flag update
  always_comb begin
    next_state = state;
    next_state.serr = serr_event;
    if (wr_acc && paddr == CMD_STATUS_OFFSET) begin
      // Only command bits are writable; of the rest only the reported flag reacts, as write one to clear
      next_state.syserr_response_enable = pwdata[SYSERR_RSP_BIT];
      next_state.parity_response_enable = pwdata[PARITY_RSP_BIT];
      next_state.bus_master_enable      = pwdata[MASTER_BIT];
      next_state.memory_space_enable    = pwdata[MEM_SPACE_BIT];
      next_state.io_space_enable        = pwdata[IO_SPACE_BIT];
      // Write one clears the reported flag
      if (pwdata[DPR_BIT]) begin
        next_state.data_parity_reported = 1'b0;
      end
    end
    if (wr_acc && paddr == HOST_STAT_OFFSET && pwdata[HOST_SYSERR_BIT]) begin
      next_state.host_syserr = 1'b0;
    end
    // Sets win over a same-cycle clear
    if (dpr_event) begin
      next_state.data_parity_reported = 1'b1;
    end
    if (hse_event) begin
      next_state.host_syserr = 1'b1;
    end
    if (rd_acc) begin
      next_state.slverr = 1'b0;
      unique case (paddr)
        CMD_STATUS_OFFSET: next_state.rdata = cmd_word;
        CLASS_REV_OFFSET:  next_state.rdata = class_word;
        IRQ_STATUS_OFFSET: next_state.rdata = {{(32-EV_COUNT){1'b0}}, irq_bus.status};
        IRQ_ENABLE_OFFSET: next_state.rdata = {{(32-EV_COUNT){1'b0}}, irq_bus.enable};
        HOST_STAT_OFFSET:  next_state.rdata = 32'(state.host_syserr) << HOST_SYSERR_BIT;
        IRQ_CLEAR_OFFSET:  next_state.rdata = '0;
        default: begin
          // Unmapped read answers zero with an error
          next_state.rdata  = '0;
          next_state.slverr = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                        <= '0;
      state.bus_master_enable      <= MASTER_RESET;
      state.parity_response_enable <= PARITY_RESET;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Interrupt unit hookup
  assign irq_bus.events    = {hse_event, serr_event, dpr_event};
  assign irq_bus.enable_wr = {EV_COUNT{wr_acc && paddr == IRQ_ENABLE_OFFSET}};
  assign irq_bus.clear_wr  = {EV_COUNT{wr_acc && paddr == IRQ_CLEAR_OFFSET}};
  assign irq_bus.wdata     = pwdata;

  ccsc_irq_unit u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .irq_bus (irq_bus.unit)
  );

  // Write errors on unmapped addresses are flagged combinationally; read-only class and status offsets are accepted
  function automatic logic wr_bad(input logic [7:0] a);
    wr_bad = !(a == CMD_STATUS_OFFSET || a == CLASS_REV_OFFSET || a == IRQ_ENABLE_OFFSET ||
               a == IRQ_CLEAR_OFFSET || a == HOST_STAT_OFFSET || a == IRQ_STATUS_OFFSET);
  endfunction

  // APB answer: always ready in the access phase
  assign pready  = 1'b1;
  assign prdata  = state.rdata;
  assign pslverr = psel && penable && (pwrite ? wr_bad(paddr) : state.slverr);

  // Gated enables toward the core
  assign mem_respond     = mem_access && state.memory_space_enable;
  assign io_respond      = io_access && state.io_space_enable;
  assign master_grant_ok = master_request && state.bus_master_enable;
  assign serr_assert     = state.serr;
  assign host_syserr     = state.host_syserr;
  assign irq             = irq_bus.irq;
endmodule

// ---- core/ccsc_pkg.sv ----
// Package: offsets, field positions and reset values of the command/status and class registers
package ccsc_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CLASS_REV_OFFSET  = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h44;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h48;
  localparam logic [7:0] HOST_STAT_OFFSET  = 8'h4C;
  // Command/status field positions
  localparam int IO_SPACE_BIT   = 0;
  localparam int MEM_SPACE_BIT  = 1;
  localparam int MASTER_BIT     = 2;
  localparam int PARITY_RSP_BIT = 6;
  localparam int SYSERR_RSP_BIT = 8;
  localparam int CAP_LIST_BIT   = 20;
  localparam int FAST_B2B_BIT   = 23;
  localparam int DPR_BIT        = 24;
  localparam int DEVSEL_LSB     = 25;
  localparam int DEVSEL_MSB     = 26;
  // Host status register system-error flag position
  localparam int HOST_SYSERR_BIT = 13;
  // Constant field values
  localparam logic [1:0] DEVSEL_MEDIUM   = 2'h1;
  localparam logic [7:0] BASE_CLASS_NET  = 8'h02;
  localparam logic [7:0] SUBCLASS_FE     = 8'h00;
  // Command reset values
  localparam logic       MASTER_RESET    = 1'h1;
  localparam logic       PARITY_RESET    = 1'h0;
  // Interrupt event bit positions
  localparam int EV_DPR    = 0;
  localparam int EV_SERR   = 1;
  localparam int EV_HOSTSE = 2;
  localparam int EV_COUNT  = 3;
  // Class register layout
  localparam int CLASS_BASE_LSB = 24;
  localparam int CLASS_SUB_LSB  = 16;
  localparam int CLASS_REV_LSB  = 4;
endpackage

// ---- core/ccsc_irq_if.sv ----
// Interface carrying event pulses and interrupt control between the bank and the interrupt unit
`timescale 1ns/1ps
interface ccsc_irq_if;
  import ccsc_pkg::*;
  logic [EV_COUNT-1:0] events;
  logic [EV_COUNT-1:0] enable_wr;
  logic [EV_COUNT-1:0] clear_wr;
  logic [31:0]         wdata;
  logic [EV_COUNT-1:0] status;
  logic [EV_COUNT-1:0] enable;
  logic                irq;
  modport bank (output events, output enable_wr, output clear_wr, output wdata,
                input status, input enable, input irq);
  modport unit (input events, input enable_wr, input clear_wr, input wdata,
                output status, output enable, output irq);
endinterface

// ---- core/ccsc_irq_unit.sv ----
// Sticky event status with enable mask and level interrupt
`timescale 1ns/1ps
module ccsc_irq_unit
  import ccsc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Bank side
  ccsc_irq_if.unit irq_bus
);
  typedef struct packed {
    logic [EV_COUNT-1:0] status;
    logic [EV_COUNT-1:0] enable;
  } ccsc_irq_state_type;
  ccsc_irq_state_type state;
  ccsc_irq_state_type next_state;

  // Set wins over a same-cycle clear so no event is lost
  always_comb begin
    next_state = state;
    if (irq_bus.enable_wr[0]) begin
      next_state.enable = irq_bus.wdata[EV_COUNT-1:0];
    end
    if (irq_bus.clear_wr[0]) begin
      next_state.status = state.status & ~irq_bus.wdata[EV_COUNT-1:0];
    end
    next_state.status = next_state.status | irq_bus.events;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Outputs
  assign irq_bus.status = state.status;
  assign irq_bus.enable = state.enable;
  assign irq_bus.irq    = |(state.status & state.enable);
endmodule

// ---- verification/ccsc_bank_sva.sv ----
// Port checker for the command/status and class register bank
`timescale 1ns/1ps
module ccsc_bank_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  // Bus events and indications
  input wire logic        addr_parity_err,
  input wire logic        parity_err,
  input wire logic        mem_access,
  input wire logic        io_access,
  input wire logic        master_request,
  input wire logic        mem_respond,
  input wire logic        io_respond,
  input wire logic        master_grant_ok,
  input wire logic        serr_assert,
  input wire logic        host_syserr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read setup; data is captured at this edge
  sequence rd_setup(a);
    psel && !penable && !pwrite && clk_en && paddr == a;
  endsequence
  // Fixed status and class fields seen on every status and class read
  chk_devsel_medium: assert property (rd_setup(8'h04) |=> prdata[27:25] == 3'h1)
    else $error("devsel timing field wrong");
  chk_fixed_caps: assert property (rd_setup(8'h04) |=> prdata[23:20] == 4'h9)
    else $error("fast b2b or capability bit wrong");
  chk_status_rsvd: assert property (rd_setup(8'h04) |=> prdata[19:9] == 11'h0 && prdata[5:3] == 3'h0)
    else $error("reserved status bits not zero");
  chk_class_code: assert property (rd_setup(8'h08) |=> prdata[31:8] == 24'h020000)
    else $error("class code wrong");
  // Gated outputs never fire without their request
  chk_mem_gate: assert property (mem_respond |-> mem_access)
    else $error("memory response without access");
  chk_io_gate: assert property (io_respond |-> io_access)
    else $error("io response without access");
  chk_master_gate: assert property (master_grant_ok |-> master_request)
    else $error("master grant without request");
  // Error outputs need a cause one cycle earlier
  chk_serr_cause: assert property ($rose(serr_assert) |-> $past(addr_parity_err))
    else $error("system error without address parity error");
  chk_host_cause: assert property ($rose(host_syserr) |-> $past(parity_err))
    else $error("host error flag without parity error");
endmodule
bind ccsc_bank ccsc_bank_sva i_sva (.*);

// ---- verification/ccsc_bus_model.sv ----
// Far-side bus model launching event patterns
`timescale 1ns/1ps
module ccsc_bus_model (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Requested pattern and driven events
  input wire logic [6:0] cmd,
  output logic     [6:0] ev
);
  // Registered so events change just after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev <= '0;
    end else begin
      ev <= cmd;
    end
  end
endmodule

// ---- verification/config_command_status_class_tb.sv ----
// Self-checking bench for the command/status and class bank
`timescale 1ns/1ps
module config_command_status_class_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pe, mr, ir, mg, se, hs, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, s, w, e, c, q;
  logic [6:0]  cmd, ev;
  int          errors, samples_checked;
  ccsc_bank i_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .perr_seen(ev[0]), .master_active(ev[1]), .addr_parity_err(ev[2]), .parity_err(ev[3]),
    .mem_access(ev[4]), .io_access(ev[5]), .master_request(ev[6]), .mem_respond(mr), .io_respond(ir),
    .master_grant_ok(mg), .serr_assert(se), .host_syserr(hs), .irq);
  ccsc_bus_model i_bus (.pclk, .presetn, .cmd, .ev);
  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Events held one cycle at the design inputs
  task automatic hit();
    @(posedge pclk);
    cmd <= c[6:0];
    @(posedge pclk);
    cmd <= '0;
    #1;
    chk("mem_respond", 32'(mr), 32'(c[4] & w[1]));
    chk("io_respond", 32'(ir), 32'(c[5] & w[0]));
    chk("master_ok", 32'(mg), 32'(c[6] & w[2]));
    @(posedge pclk);
    #1;
    chk("serr_assert", 32'(se), 32'(c[2] & w[8]));
    chk("host_syserr", 32'(hs), 32'(c[3] & w[6]));
    q = {29'h0, c[3] & w[6], c[2] & w[8], c[0] & c[1] & w[6]};
    chk("irq", 32'(irq), 32'(|(q & e)));
    apb(0, 8'h04, 0);
    chk("status", rd, 32'h0290_0000 | (w & 32'h147) | (32'(q[0]) << 24));
    apb(0, 8'h40, 0);
    chk("irq_status", rd, q);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cmd} = '0;
    s = 32'h5B83;
    errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h04, 0);
    chk("cmd_reset", rd, 32'h0290_0004);
    apb(1, 8'h08, 32'hFFFF_FFFF);
    apb(0, 8'h08, 0);
    chk("class", rd, 32'h0200_0010);
    apb(0, 8'h10, 0);
    chk("unmapped", {pe, rd[30:0]}, 32'h8000_0000);
    // All-on and all-off command corners first, with all events on, then random
    for (int i = 0; i < 40; i++) begin
      w = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : xs();
      e = (i < 2) ? 32'h7 : xs() & 32'h7;
      c = (i < 2) ? 32'h7F : xs();
      apb(1, 8'h04, w);
      apb(1, 8'h44, e);
      hit();
      apb(1, 8'h48, 32'h7);
      apb(1, 8'h4C, 32'h2000);
      apb(1, 8'h04, w | 32'h0100_0000);
      #1;
      chk("cleared", {31'h0, irq | hs}, 32'h0);
    end
    wrap_up();
  end
endmodule
